/* File: verilog/pag_port.sv */
// Port A pin multiplexer: eight-pin GPIO with analog and peripheral sharing.
// Assumes APB master on sys_clk; pad inputs are asynchronous.
// Overview of operation
// - Output pin drives latch, analog unaffected
// - Input pin port read off when analog; pin 5 still feeds slave select
// - Pins 0-3, 5 analog after reset
// - Pin 4 digital input after reset
// - Reference output kills pin 2 digital
// - Comparator one overrides latch on pin 4
// - Comparator two overrides latch on pin 5
// - Pin 5 input feeds slave select
// - Pin 6 I/O only in three modes
// - Pin 6 outputs quarter clock in clockout modes
// - Pin 7 digital off for external oscillator
// - Unused pins 6, 7 read zero everywhere
// - Don't-care functions override direction bit
// - Port read gives pins, write sets latch
// - Latch read returns latch contents, zero for pins not usable as I/O
// - Direction one tristates, zero drives latch
// - Analog pin reads zero digitally
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pag_port (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe_n,
    input wire logic comparator_one_out,
    input wire logic comparator_two_out,
    output logic timer_zero_clock_in,
    output logic slave_select_in
);
    import pag_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] latch_r;        // Output latch
    logic [7:0] dir_r;          // Direction, 1 is input
    logic [7:0] analog_r;       // Analog select per pin
    logic c1oe_r;               // Comparator one onto pin 4
    logic c2oe_r;               // Comparator two onto pin 5
    logic refoe_r;              // Reference output on pin 2
    pag_osc_type osc_r;         // Oscillator configuration
    logic [7:0] sync1_r;        // First synchroniser stage
    logic [7:0] sync2_r;        // Second synchroniser stage
    logic [1:0] cyc_r;          // Quarter-rate divider
    logic cyc_clk_r;            // Cycle clock
    pag_pad_type pad_nxt;       // Combined pad drive
    logic [7:0] io_en;          // Pins usable as digital I/O
    logic [7:0] pins_rd;        // Readable pin levels
    logic acc;                  // APB access phase
    logic wr_acc;               // Write access

    // Pin 6 usable as I/O in this mode
    function automatic logic six_io(input pag_osc_type m);
        six_io = (m == PAG_OSC_RC_WITH_IO) || (m == PAG_OSC_INT_WITH_IO) ||
                 (m == PAG_OSC_EXT_WITH_IO);
    endfunction

    // Pin 6 carries cycle clock in this mode
    function automatic logic six_clk(input pag_osc_type m);
        six_clk = (m == PAG_OSC_RC_CLKOUT) || (m == PAG_OSC_INT_CLKOUT) ||
                  (m == PAG_OSC_EXT_CLKOUT);
    endfunction

    // Pin 7 usable as I/O (internal oscillator only)
    function automatic logic seven_io(input pag_osc_type m);
        seven_io = (m == PAG_OSC_INT_CLKOUT) || (m == PAG_OSC_INT_WITH_IO);
    endfunction

    assign acc = psel && penable;
    assign wr_acc = acc && pwrite;

    // ************************************************************
    // Pad synchroniser
    // ************************************************************
    // Two stages before any logic looks at the pins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else if (clk_en) begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
        end
    end

    // ************************************************************
    // Pin enables and readback
    // ************************************************************
    // Digital I/O availability per pin
    always_comb begin
        io_en = 8'h3F;
        io_en[6] = six_io(osc_r);
        io_en[7] = seven_io(osc_r);
        if (refoe_r) begin
            io_en[2] = 1'b0;
        end
    end

    // Input path off for analog or disabled pins
    assign pins_rd = sync2_r & pad_nxt.ie;

    // ************************************************************
    // Output latch
    // ************************************************************
    // Port or latch write updates the latch in full
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latch_r <= PAG_LATCH_RST;
        end else if (clk_en && wr_acc) begin
            if (paddr == PAG_OFF_PINS || paddr == PAG_OFF_LATCH) begin
                latch_r <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Direction register
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dir_r <= PAG_DIR_RST;
        end else if (clk_en && wr_acc && paddr == PAG_OFF_DIR) begin
            dir_r <= pwdata[7:0];
        end
    end

    // ************************************************************
    // Configuration register
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            analog_r <= PAG_ANALOG_RST;
            c1oe_r <= 1'b0;
            c2oe_r <= 1'b0;
            refoe_r <= 1'b0;
            osc_r <= PAG_OSC_CRYSTAL;
        end else if (clk_en && wr_acc && paddr == PAG_OFF_CFG) begin
            // Only pins 0-3 and 5 can be analog
            analog_r <= pwdata[PAG_CFG_ANA_LSB +: 8] & PAG_ANALOG_RST;
            c1oe_r <= pwdata[PAG_CFG_C1OE_BIT];
            c2oe_r <= pwdata[PAG_CFG_C2OE_BIT];
            refoe_r <= pwdata[PAG_CFG_REFOE_BIT];
            if (pwdata[PAG_CFG_OSC_LSB +: 3] != 3'b111) begin
                osc_r <= pag_osc_type'(pwdata[PAG_CFG_OSC_LSB +: 3]);
            end
        end
    end

    // ************************************************************
    // Cycle clock divider
    // ************************************************************
    // Toggle every two clocks gives a quarter-rate clock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cyc_r <= 2'b00;
            cyc_clk_r <= 1'b0;
        end else if (clk_en) begin
            cyc_r <= cyc_r + 2'b01;
            if (cyc_r[0]) begin
                cyc_clk_r <= ~cyc_clk_r;
            end
        end
    end

    // ************************************************************
    // Pad drive mux
    // ************************************************************
    always_comb begin
        pad_nxt.out = latch_r;
        pad_nxt.oe_n = dir_r | ~io_en;
        pad_nxt.ie = io_en & ~analog_r;
        if (c1oe_r) begin
            pad_nxt.out[4] = comparator_one_out;
        end
        if (c2oe_r) begin
            pad_nxt.out[5] = comparator_two_out;
        end
        if (six_clk(osc_r)) begin
            pad_nxt.out[6] = cyc_clk_r;
            pad_nxt.oe_n[6] = 1'b0;
        end
    end

    // Registered pad outputs and peripheral inputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pad_out <= 8'h00;
            pad_oe_n <= 8'hFF;
            timer_zero_clock_in <= 1'b0;
            slave_select_in <= 1'b1;
        end else if (clk_en) begin
            pad_out <= pad_nxt.out;
            pad_oe_n <= pad_nxt.oe_n;
            timer_zero_clock_in <= sync2_r[4];
            if (dir_r[5]) begin
                slave_select_in <= sync2_r[5];
            end else begin
                slave_select_in <= 1'b1;
            end
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    // Zero-wait answers, unmapped addresses flag an error
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == PAG_OFF_PINS) begin
                    prdata <= {24'h00_0000, pins_rd};
                end else if (paddr == PAG_OFF_LATCH) begin
                    prdata <= {24'h00_0000,
                               latch_r & io_en};
                end else if (paddr == PAG_OFF_DIR) begin
                    prdata <= {24'h00_0000, dir_r & io_en};
                end else if (paddr == PAG_OFF_CFG) begin
                    prdata <= {17'h0_0000, osc_r, 1'b0, refoe_r, c2oe_r,
                               c1oe_r, analog_r};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // Pin 0 has no alternate output, so it shows the latch directly
    a_latch_drive: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && !dir_r[0] ##1 1'b1 |-> pad_out[0] == $past(latch_r[0]))
        else $error("pin 0 not driven from latch");
    a_analog_read: assert property (
        @(posedge sys_clk) disable iff (srst)
        analog_r[0] |-> pins_rd[0] == 1'b0)
        else $error("analog pin reads nonzero");
    // Reset checks look at the first edge after release
    a_reset_analog: assert property (
        @(posedge sys_clk)
        srst ##1 !srst |-> analog_r == PAG_ANALOG_RST)
        else $error("analog reset value wrong");
    a_reset_dir: assert property (
        @(posedge sys_clk)
        srst ##1 !srst |-> dir_r[4] && !analog_r[4])
        else $error("pin 4 not digital input");
    a_ref_off: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && refoe_r ##1 1'b1 |-> pad_oe_n[2])
        else $error("pin 2 driven with reference on");
    a_cmp_one: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && c1oe_r && !dir_r[4] |=>
            pad_out[4] == $past(comparator_one_out))
        else $error("comparator one not on pin 4");
    a_cmp_two: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && c2oe_r && !dir_r[5] |=>
            pad_out[5] == $past(comparator_two_out))
        else $error("comparator two not on pin 5");
    a_seven_zero: assert property (
        @(posedge sys_clk) disable iff (srst)
        !seven_io(osc_r) |-> !pins_rd[7] && !io_en[7])
        else $error("pin 7 visible while oscillator");
    a_latch_write: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && wr_acc && paddr == PAG_OFF_PINS |=>
            latch_r == $past(pwdata[7:0]))
        else $error("port write missed latch");
    // Pin 5 driven by the port must not look like a select
    a_ssel_output: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && !dir_r[5] |=> slave_select_in)
        else $error("slave select active while pin 5 drives");
    a_clk_forced: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && six_clk(osc_r) |=> !pad_oe_n[6])
        else $error("cycle clock pin not driven");
    a_div_toggle: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && cyc_r[0] |=> cyc_clk_r != $past(cyc_clk_r))
        else $error("cycle clock missed a toggle");
    a_seven_off: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && !seven_io(osc_r) |=> pad_oe_n[7])
        else $error("pin 7 driven while oscillator");
    a_dir_tristate: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && dir_r[1] |=> pad_oe_n[1])
        else $error("input pin 1 driven");
    // Read data is chosen at the setup edge
    a_pin_read: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && psel && !penable && paddr == PAG_OFF_PINS |=>
            prdata[7:0] == $past(pins_rd))
        else $error("port read not pin levels");
    a_latch_read: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && psel && !penable && paddr == PAG_OFF_LATCH |=>
            prdata[7:0] == $past(latch_r & io_en))
        else $error("latch read not latch contents");
    // Main scenarios worth seeing once
    c_clkout: cover property (@(posedge sys_clk) six_clk(osc_r) && !pad_oe_n[6]);
    c_cmp_one: cover property (@(posedge sys_clk) c1oe_r && !pad_oe_n[4]);
    c_err: cover property (@(posedge sys_clk) pready && pslverr);
    c_ref_on: cover property (@(posedge sys_clk) refoe_r && pad_oe_n[2]);
    c_ssel_low: cover property (
        @(posedge sys_clk) dir_r[5] && !slave_select_in);
endmodule
`default_nettype wire

/* File: inc/pag_pkg.sv */
// Package for the port A pin multiplexer block.
// Assumes a 32-bit APB slave on sys_clk; included before the design file.
package pag_pkg;
    // ************************************************************
    // Register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [11:0] PAG_OFF_PINS = 12'h000;  // Pin levels / latch write
    localparam logic [11:0] PAG_OFF_LATCH = 12'h004; // Output latch
    localparam logic [11:0] PAG_OFF_DIR = 12'h008;   // Direction
    localparam logic [11:0] PAG_OFF_CFG = 12'h00C;   // Mux configuration
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] PAG_LATCH_RST = 8'h00;
    localparam logic [7:0] PAG_DIR_RST = 8'hFF;      // All inputs
    localparam logic [7:0] PAG_ANALOG_RST = 8'h2F;   // Pins 0-3 and 5 analog
    localparam logic [2:0] PAG_OSC_RST = 3'h0;
    // ************************************************************
    // Configuration word field positions
    // ************************************************************
    localparam int PAG_CFG_ANA_LSB = 0;   // Analog select, 8 bits
    localparam int PAG_CFG_C1OE_BIT = 8;  // Comparator one onto pin 4
    localparam int PAG_CFG_C2OE_BIT = 9;  // Comparator two onto pin 5
    localparam int PAG_CFG_REFOE_BIT = 10; // Reference output on pin 2
    localparam int PAG_CFG_OSC_LSB = 12;  // Oscillator mode, 3 bits
    // ************************************************************
    // Oscillator configurations
    // ************************************************************
    typedef enum logic [2:0] {
        PAG_OSC_CRYSTAL = 3'b000,          // Both pins used by oscillator
        PAG_OSC_RC_CLKOUT = 3'b001,        // Pin 6 cycle clock, pin 7 osc
        PAG_OSC_RC_WITH_IO = 3'b010,       // Pin 6 I/O, pin 7 osc
        PAG_OSC_INT_CLKOUT = 3'b011,       // Pin 6 cycle clock, pin 7 I/O
        PAG_OSC_INT_WITH_IO = 3'b100,      // Both pins I/O
        PAG_OSC_EXT_CLKOUT = 3'b101,       // Pin 6 cycle clock, pin 7 osc
        PAG_OSC_EXT_WITH_IO = 3'b110       // Pin 6 I/O, pin 7 osc
    } pag_osc_type;
    // Bundle of pad signals
    typedef struct packed {
        logic [7:0] out;    // Pad output value
        logic [7:0] oe_n;   // Output enable, low drives
        logic [7:0] ie;     // Digital input path enabled
    } pag_pad_type;
endpackage

/* File: test/pag_board.sv */
// Board model for the port A pads.
// Assumes pad drive from pag_port and a board level set by the bench.
`timescale 1ns/100ps
`default_nettype none
module pag_board (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] ext_level,
    output logic [7:0] pad_in
);
    // ************************************************************
    // Pad levels
    // ************************************************************
    // Driven pads read back, released pads take the board level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_in[i] = pad_oe_n[i] ? ext_level[i] : pad_out[i];
        end
    end
endmodule
`default_nettype wire

/* File: test/port_a_pin_mux_io_tb.sv */
// Testbench for the port A pin multiplexer.
// Assumes pag_pkg, pag_port and pag_board are compiled first.
`timescale 1ns/100ps
`default_nettype none
module port_a_pin_mux_io_tb;
    import pag_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam logic [7:0] IO6 = 8'h54; // Modes with pin 6 as I/O
    localparam logic [7:0] IO7 = 8'h18; // Modes with pin 7 as I/O
    localparam logic [7:0] CK6 = 8'h2A; // Modes with clock on pin 6
    logic sys_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic c1, c2, tmr_in, ssel, slv, prev, en;
    logic [7:0] pad_in, pad_out, pad_oe_n, ext;
    int bad_count, comparisons, rises;
    pag_port uut (.sys_clk(sys_clk), .srst(srst), .clk_en(en),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .comparator_one_out(c1), .comparator_two_out(c2),
        .timer_zero_clock_in(tmr_in), .slave_select_in(ssel));
    pag_board board (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .ext_level(ext), .pad_in(pad_in));
    // ************************************************************
    // Tasks
    // ************************************************************
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            bad_count++;
            test_done();
        end else begin
            rd = prdata;
            slv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, rd, exp);
    endtask
    // Let pad drive and input sync settle
    task automatic settle();
        repeat (4) @(posedge sys_clk);
    endtask
    // Count rising edges of the pin 6 drive over 16 clocks
    task automatic count_rises();
        rises = 0;
        prev = pad_out[6];
        repeat (16) begin
            @(posedge sys_clk);
            if (pad_out[6] === 1'b1 && prev === 1'b0) begin
                rises++;
            end
            prev = pad_out[6];
        end
    endtask
    // ************************************************************
    // Clock and sequence
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, c1, c2} = 5'h00;
        en = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ext = 8'hFF;
        bad_count = 0;
        comparisons = 0;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        settle();
        // Defaults after reset
        chk("oe reset", 32'(pad_oe_n), 32'h0000_00FF);
        rdchk("pins reset", PAG_OFF_PINS, 32'h0000_0010);
        rdchk("dir reset", PAG_OFF_DIR, 32'h0000_003F);
        rdchk("cfg reset", PAG_OFF_CFG, 32'h0000_002F);
        chk("timer in", 32'(tmr_in), 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped", 32'(slv), 32'h0000_0001);
        // Port write sets latch, pins drive it
        wr(PAG_OFF_CFG, 32'h0000_4000);
        wr(PAG_OFF_PINS, 32'h0000_00A5);
        rdchk("latch", PAG_OFF_LATCH, 32'h0000_00A5);
        wr(PAG_OFF_DIR, 32'h0000_0000);
        settle();
        chk("drive", 32'(pad_out), 32'h0000_00A5);
        chk("oe out", 32'(pad_oe_n), 32'h0000_0000);
        rdchk("pins out", PAG_OFF_PINS, 32'h0000_00A5);
        wr(PAG_OFF_LATCH, 32'h0000_005A);
        rdchk("latch wr", PAG_OFF_LATCH, 32'h0000_005A);
        // Analog select keeps drive, kills input path
        wr(PAG_OFF_CFG, 32'h0000_402F);
        settle();
        chk("ana drive", 32'(pad_out), 32'h0000_005A);
        wr(PAG_OFF_DIR, 32'h0000_00FF);
        settle();
        rdchk("ana pins", PAG_OFF_PINS, 32'h0000_00D0);
        // Reference output on pin 2
        wr(PAG_OFF_CFG, 32'h0000_4400);
        wr(PAG_OFF_DIR, 32'h0000_0000);
        settle();
        chk("ref oe", 32'(pad_oe_n), 32'h0000_0004);
        rdchk("ref pins", PAG_OFF_PINS, 32'h0000_005A);
        // Comparator outputs beat latch on pins 4, 5
        wr(PAG_OFF_CFG, 32'h0000_4300);
        wr(PAG_OFF_DIR, 32'h0000_0000);
        c1 <= 1'b0;
        c2 <= 1'b1;
        settle();
        chk("comp", 32'(pad_out[5:4]), 32'h0000_0002);
        // Slave select follows pin 5 only as input
        wr(PAG_OFF_CFG, 32'h0000_4000);
        ext <= 8'hDF;
        wr(PAG_OFF_DIR, 32'h0000_00FF);
        settle();
        chk("ssel in", 32'(ssel), 32'h0000_0000);
        wr(PAG_OFF_DIR, 32'h0000_0000);
        settle();
        chk("ssel out", 32'(ssel), 32'h0000_0001);
        // Oscillator modes on pins 6, 7
        wr(PAG_OFF_LATCH, 32'h0000_00C0);
        for (int m = 0; m < 7; m++) begin
            wr(PAG_OFF_CFG, {17'h0_0000, m[2:0], 12'h000});
            settle();
            rdchk("osc latch", PAG_OFF_LATCH,
                {24'h00_0000, IO7[m], IO6[m], 6'h00});
            chk("osc oe", 32'(pad_oe_n[7:6]),
                32'({~IO7[m], ~(IO6[m] | CK6[m])}));
        end
        // Reserved mode code leaves the last mode in place
        wr(PAG_OFF_CFG, 32'h0000_7000);
        rdchk("osc keep", PAG_OFF_LATCH, 32'h0000_0040);
        // Cycle clock on pin 6 whatever the direction
        wr(PAG_OFF_CFG, 32'h0000_3000);
        wr(PAG_OFF_DIR, 32'h0000_00FF);
        settle();
        rdchk("dir osc", PAG_OFF_DIR, 32'h0000_00BF);
        chk("clk oe", 32'(pad_oe_n[6]), 32'h0000_0000);
        count_rises();
        chk("clk rises", 32'(rises), 32'h0000_0004);
        // Clock enable low freezes the divider and the pads
        en <= 1'b0;
        @(posedge sys_clk);
        count_rises();
        chk("clk frozen", 32'(rises), 32'h0000_0000);
        // Reset in mid-run restores the defaults
        en <= 1'b1;
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        settle();
        chk("oe rerst", 32'(pad_oe_n), 32'h0000_00FF);
        rdchk("pins rerst", PAG_OFF_PINS, 32'h0000_0010);
        test_done();
    end
endmodule
`default_nettype wire
